// File: include/mic_pkg.sv
package mic_pkg;

	// ------------------------------------------------------------
	// register map: word indices, byte address is four times index
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [13:0] IDX_INTERRUPT_CONTROL = 14'h000b;
	localparam logic [13:0] IDX_FLAG_GROUP0 = 14'h070c;
	localparam logic [13:0] IDX_FLAG_GROUP1 = 14'h070d;
	localparam logic [13:0] IDX_ENABLE_GROUP0 = 14'h0716;
	localparam logic [13:0] IDX_ENABLE_GROUP1 = 14'h0717;
	localparam logic [13:0] IDX_CORE_STATUS = 14'h0720;
	localparam logic [13:0] IDX_EXT_PIN_ROUTE = 14'h1e90;
	localparam logic [13:0] IDX_SHADOW_BASE = 14'h1f84;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int GIE_BIT = 7;
	localparam int PERIPH_IRQ_ENABLE_BIT = 6;
	localparam int EDGE_BIT = 0;
	localparam int TIMER_ZERO_BIT = 5;
	localparam int PIN_CHANGE_BIT = 4;
	localparam int EXT_PIN_BIT = 0;
	localparam int TIMEOUT_BIT = 4;
	localparam int POWERDOWN_BIT = 3;
	// group1 bits that mirror a live source level and ignore writes
	localparam logic [7:0] GROUP1_LEVEL_MASK = 8'h18;

	// ------------------------------------------------------------
	// reset values and fixed addresses
	// ------------------------------------------------------------
	localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic [7:0] SHADOW_RESET = 8'h00;
	localparam logic [14:0] VECTOR_ADDR = 15'h0004;

	// ------------------------------------------------------------
	// instruction cycle phases and shadow slots
	// ------------------------------------------------------------
	localparam logic [1:0] PHASE_Q1 = 2'h0;
	localparam logic [1:0] PHASE_Q4 = 2'h3;
	localparam int SHADOW_COUNT = 8;
	localparam int SHADOW_STATUS = 1;

	typedef enum logic [1:0] {
		MIC_RUN,
		MIC_ASLEEP,
		MIC_WAKE_HOLD
	} mic_core_state_type;

endpackage

// File: verif/mic_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core pipeline stand-in
// ----------------------------------------
module mic_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_entry,
	input wire logic wake,
	input wire logic sleep_req,
	input wire logic [7:0] ret_wait,
	output logic core_sleep,
	output logic core_return
);
	logic [7:0] cnt_reg;
	logic busy_reg;

	// handler runs ret_wait plus one clocks, then the return instruction
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			core_return <= 1'b0;
		end else begin
			core_return <= 1'b0;
			if (irq_entry) begin
				busy_reg <= 1'b1;
				cnt_reg <= ret_wait;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 8'h01;
				busy_reg <= cnt_reg != 8'h00;
				core_return <= cnt_reg == 8'h00;
			end
		end
	end

	// sleep until woken; wake or reset are the only ways out
	always_ff @(posedge clk) begin
		if (rst) core_sleep <= 1'b0;
		else if (wake) core_sleep <= 1'b0;
		else if (sleep_req) core_sleep <= 1'b1;
	end
endmodule

// File: verif/mic_intctl_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port timing checks
// ----------------------------------------
module mic_intctl_assertions (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [1:0] Q_PHASE,
	input wire logic IRQ_ENTRY,
	input wire logic [14:0] VECTOR_PC,
	input wire logic IRQ_PENDING,
	input wire logic CORE_RETURN,
	input wire logic RESTORE_STROBE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	// bus answers in exactly one access cycle
	chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing after setup");
	chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	chk_slverr_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("error outside access");
	// phase counter; first cycle after reset is skipped on purpose
	chk_phase_steps: assert property (!$past(SYS_RST) |-> Q_PHASE == 2'($past(Q_PHASE) + 2'h1))
		else $error("phase did not advance");
	chk_entry_in_q2: assert property (IRQ_ENTRY |-> Q_PHASE == 2'h1)
		else $error("entry outside q2");
	chk_entry_drops_enable: assert property (IRQ_ENTRY |-> IRQ_PENDING ##1 !IRQ_PENDING && !IRQ_ENTRY)
		else $error("entry did not clear global enable");
	chk_vector_fixed: assert property (VECTOR_PC == 15'h0004)
		else $error("vector address wrong");
	chk_restore_follows: assert property (RESTORE_STROBE == $past(CORE_RETURN))
		else $error("restore strobe misplaced");

	cov_entry: cover property (IRQ_ENTRY);
	cov_restore: cover property (RESTORE_STROBE);
	cov_slverr: cover property (PSLVERR);
endmodule

bind mic_intctl mic_intctl_assertions u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .Q_PHASE(Q_PHASE),
	.IRQ_ENTRY(IRQ_ENTRY), .VECTOR_PC(VECTOR_PC), .IRQ_PENDING(IRQ_PENDING),
	.CORE_RETURN(CORE_RETURN), .RESTORE_STROBE(RESTORE_STROBE));

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	import mic_pkg::*;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, tz_ev, rd_err;
	logic core_sleep, core_return, irq_entry, irq_pending, wake, restore_strobe, sleep_req;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] ext_pins, periph_ev, rd_q, ret_wait;
	logic [2:0] ioc;
	logic [1:0] q_phase;
	logic [14:0] vector_pc;
	logic [63:0] core_ctx, restore_ctx;
	int fails, num_checks, n_entry, n, e0;

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// entries counted to check that none, or exactly one, happened
	always @(posedge ref_clk) if (irq_entry === 1'b1) n_entry <= n_entry + 1;

	mic_intctl u_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .EXT_PINS(ext_pins), .TIMER_ZERO_EVENT(tz_ev),
		.PERIPH_EVENT(periph_ev), .IOC_PORT_FLAGS(ioc), .CORE_SLEEP(core_sleep),
		.CORE_RETURN(core_return), .CORE_CONTEXT(core_ctx), .Q_PHASE(q_phase),
		.IRQ_ENTRY(irq_entry), .VECTOR_PC(vector_pc), .IRQ_PENDING(irq_pending), .WAKE(wake),
		.RESTORE_STROBE(restore_strobe), .RESTORE_CONTEXT(restore_ctx));
	mic_core_model u_core (.clk(ref_clk), .rst(sys_rst), .irq_entry(irq_entry), .wake(wake),
		.sleep_req(sleep_req), .ret_wait(ret_wait), .core_sleep(core_sleep),
		.core_return(core_return));

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task conclude();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until pready is seen at a rising edge
	task apb(input logic w, input logic [13:0] i, input logic [7:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			fails++;
			conclude();
		end
		rd_q = prdata[7:0];
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [13:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask
	task rd(input logic [13:0] i, input logic [7:0] exp);
		apb(1'b0, i, 8'h00);
		chk(rd_q, exp);
	endtask
	// sel 0 entry, 1 restore, 2 wake; n counts clocks
	task wait_hi(input int sel);
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			if ((sel == 0 ? irq_entry : sel == 1 ? restore_strobe : wake) === 1'b1) break;
		end
		if (n == 40) begin
			fails++;
			conclude();
		end
	endtask
	task pulse_tz();
		@(posedge ref_clk);
		tz_ev <= 1'b1;
		@(posedge ref_clk);
		tz_ev <= 1'b0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset_regs();
		rd(IDX_INTERRUPT_CONTROL, 8'h00);
		rd(IDX_ENABLE_GROUP1, 8'h00);
		wr(IDX_ENABLE_GROUP0, 8'hff);
		rd(IDX_ENABLE_GROUP0, 8'h31);
		wr(IDX_ENABLE_GROUP1, 8'hff);
		rd(IDX_ENABLE_GROUP1, 8'hff);
		wr(IDX_ENABLE_GROUP1, 8'h00);
		wr(IDX_ENABLE_GROUP0, 8'h00);
		wr(IDX_INTERRUPT_CONTROL, 8'h41);
		rd(IDX_INTERRUPT_CONTROL, 8'h41);
		rd(14'h0001, 8'h00);
		chk(rd_err, 1'b1);
	endtask
	task t_entry_return();
		pulse_tz();
		rd(IDX_FLAG_GROUP0, 8'h20);
		chk(n_entry, 0);
		wr(IDX_FLAG_GROUP0, 8'h00);
		wr(IDX_ENABLE_GROUP0, 8'h20);
		wr(IDX_INTERRUPT_CONTROL, 8'hc1);
		pulse_tz();
		wait_hi(0);
		chk(n <= 16, 1'b1);
		core_ctx <= 64'h0;
		rd(IDX_INTERRUPT_CONTROL, 8'h41);
		wr(IDX_FLAG_GROUP0, 8'h00);
		wr(IDX_SHADOW_BASE, 8'h5a);
		rd(IDX_SHADOW_BASE, 8'h5a);
		wait_hi(1);
		chk(restore_ctx, 64'h887766554433235a);
		rd(IDX_INTERRUPT_CONTROL, 8'hc1);
		wr(IDX_INTERRUPT_CONTROL, 8'h00);
	endtask
	task t_periph_gate();
		ret_wait <= 8'h04;
		wr(IDX_ENABLE_GROUP1, 8'h01);
		wr(IDX_INTERRUPT_CONTROL, 8'h80);
		@(posedge ref_clk);
		periph_ev <= 8'h01;
		@(posedge ref_clk);
		periph_ev <= 8'h00;
		e0 = n_entry;
		repeat (20) @(posedge ref_clk);
		chk(n_entry, e0);
		wr(IDX_INTERRUPT_CONTROL, 8'hc0);
		wait_hi(0);
		wr(IDX_FLAG_GROUP1, 8'h00);
		wait_hi(1);
		wr(IDX_INTERRUPT_CONTROL, 8'h00);
		wr(IDX_ENABLE_GROUP0, 8'h00);
	endtask
	task t_ext_pin();
		wr(IDX_EXT_PIN_ROUTE, 8'h02);
		wr(IDX_INTERRUPT_CONTROL, 8'h01);
		wr(IDX_FLAG_GROUP0, 8'h00);
		ext_pins <= 8'h20;
		repeat (8) @(posedge ref_clk);
		rd(IDX_FLAG_GROUP0, 8'h00);
		ext_pins <= 8'h24;
		repeat (8) @(posedge ref_clk);
		rd(IDX_FLAG_GROUP0, 8'h01);
		wr(IDX_INTERRUPT_CONTROL, 8'h00);
		wr(IDX_FLAG_GROUP0, 8'h00);
		ext_pins <= 8'h00;
		repeat (8) @(posedge ref_clk);
		rd(IDX_FLAG_GROUP0, 8'h01);
		wr(IDX_FLAG_GROUP0, 8'h00);
	endtask
	task t_pin_change();
		ioc <= 3'b110;
		repeat (2) @(posedge ref_clk);
		rd(IDX_FLAG_GROUP0, 8'h10);
		ioc <= 3'b100;
		repeat (2) @(posedge ref_clk);
		rd(IDX_FLAG_GROUP0, 8'h10);
		ioc <= 3'b000;
		repeat (2) @(posedge ref_clk);
		rd(IDX_FLAG_GROUP0, 8'h00);
	endtask
	task t_sleep_wake();
		wr(IDX_ENABLE_GROUP0, 8'h20);
		@(posedge ref_clk);
		sleep_req <= 1'b1;
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		e0 = n_entry;
		pulse_tz();
		wait_hi(2);
		repeat (16) @(posedge ref_clk);
		chk(n_entry, e0);
		chk(core_sleep, 1'b0);
		wr(IDX_FLAG_GROUP0, 8'h00);
	endtask
	// global enable set: one q1 skipped after wake, then the vector
	task t_sleep_vector();
		wr(IDX_ENABLE_GROUP0, 8'h20);
		wr(IDX_INTERRUPT_CONTROL, 8'h80);
		@(posedge ref_clk);
		sleep_req <= 1'b1;
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		e0 = n_entry;
		pulse_tz();
		wait_hi(2);
		chk(n_entry, e0);
		wait_hi(0);
		chk(n >= 6 && n <= 9, 1'b1);
		wr(IDX_FLAG_GROUP0, 8'h00);
		wait_hi(1);
		chk(n_entry, e0 + 1);
		wr(IDX_INTERRUPT_CONTROL, 8'h00);
		wr(IDX_ENABLE_GROUP0, 8'h00);
	endtask
	// second reset in mid-run must drop every enable and the group0 flags
	task t_mid_reset();
		wr(IDX_ENABLE_GROUP0, 8'h31);
		wr(IDX_ENABLE_GROUP1, 8'hff);
		wr(IDX_INTERRUPT_CONTROL, 8'h41);
		pulse_tz();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(IDX_INTERRUPT_CONTROL, 8'h00);
		rd(IDX_ENABLE_GROUP0, 8'h00);
		rd(IDX_ENABLE_GROUP1, 8'h00);
		rd(IDX_FLAG_GROUP0, 8'h00);
		rd(IDX_CORE_STATUS, 8'h00);
	endtask

	initial begin
		{sys_rst, psel, penable, pwrite, tz_ev, sleep_req} = 6'b100000;
		{paddr, pwdata, ext_pins, periph_ev, ioc} = '0;
		{fails, num_checks, n_entry} = '0;
		ret_wait = 8'h1e;
		core_ctx = 64'h8877665544333b11;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset_regs();
		t_entry_return();
		t_periph_gate();
		t_ext_pin();
		t_pin_change();
		t_sleep_wake();
		t_sleep_vector();
		t_mid_reset();
		conclude();
	end
endmodule

// File: verilog/mic_intctl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - any reset leaves every interrupt disabled
// - flags set regardless of any enable
// - entry clears global enable, saves, vectors 0004h
// - global enable clear holds requests pending
// - return restores context and sets global enable
// - request sampled at Q1, fixed latency
// - external flag acted upon at next Q1
// - wake from sleep, one instruction before vector
// - edge select picks rising or falling edge
// - valid edge sets external flag, may vector
// - group0 sources need only global enable
// - group1 sources also need peripheral enable
// - shadow core context, status minus timeout/powerdown
// - shadows read/writable, written value restored
// - control register bits 7, 6, 0
// - group0 enables at bits 5, 4, 0
// - group1 enables eight peripheral sources
// - external pin chosen by route select
// - pin-change flag is OR of port flags
module mic_intctl
	import mic_pkg::*;
#(
	parameter int PIN_COUNT = 8,
	parameter int IOC_PORTS = 3
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [mic_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [PIN_COUNT-1:0] EXT_PINS,
	input wire logic TIMER_ZERO_EVENT,
	input wire logic [7:0] PERIPH_EVENT,
	input wire logic [IOC_PORTS-1:0] IOC_PORT_FLAGS,
	input wire logic CORE_SLEEP,
	input wire logic CORE_RETURN,
	input wire logic [63:0] CORE_CONTEXT,
	output logic [1:0] Q_PHASE,
	output logic IRQ_ENTRY,
	output logic [14:0] VECTOR_PC,
	output logic IRQ_PENDING,
	output logic WAKE,
	output logic RESTORE_STROBE,
	output logic [63:0] RESTORE_CONTEXT
);
	import mic_pkg::*;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] control_reg;
	logic [7:0] enable0_reg;
	logic [7:0] enable1_reg;
	logic [7:0] route_reg;
	logic timer_zero_flag_reg;
	logic ext_pin_flag_reg;
	logic [7:0] flag1_reg;
	logic [7:0] shadow_reg [SHADOW_COUNT];
	logic ext_prev_reg;
	mic_core_state_type state_reg;
	logic pready_reg;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [13:0] word_idx;
	logic bus_write;
	logic shadow_hit;
	logic [2:0] shadow_slot;
	logic mapped;
	logic [7:0] rd_next;
	logic [13:0] shadow_off;

	assign word_idx = PADDR[15:2];
	// a write lands only on the access edge the master samples
	assign bus_write = PSEL & PENABLE & PWRITE & pready_reg;
	assign shadow_off = word_idx - IDX_SHADOW_BASE;
	assign shadow_hit = (word_idx >= IDX_SHADOW_BASE)
		&& (shadow_off < 14'(SHADOW_COUNT));
	assign shadow_slot = shadow_off[2:0];

	// ------------------------------------------------------------
	// request logic
	// ------------------------------------------------------------
	logic ext_sync;
	logic [PIN_COUNT-1:0] route_onehot;
	logic routed_pin;
	logic ext_edge;
	logic pin_change_flag;
	logic [7:0] flag0_view;
	logic [7:0] flag1_next;
	logic group0_hit;
	logic group1_hit;
	logic pending_any;
	logic request;
	logic sample_q1;
	logic take_irq;

	// pin multiplexed ahead of the synchroniser; a route change can
	// produce one spurious edge, so software changes route with the
	// external enable clear and clears the flag afterwards
	always_comb begin
		route_onehot = '0;
		route_onehot[route_reg[$clog2(PIN_COUNT)-1:0]] = 1'b1;
		routed_pin = |(EXT_PINS & route_onehot);
	end

	mic_sync2 #(
		.WIDTH(1)
	) u_ext_sync (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.async_in(routed_pin),
		.sync_out(ext_sync)
	);

	// edge select: rising when set, falling when clear
	assign ext_edge = control_reg[EDGE_BIT] ? (ext_sync & ~ext_prev_reg)
		: (~ext_sync & ext_prev_reg);

	assign pin_change_flag = |IOC_PORT_FLAGS;

	always_comb begin
		flag0_view = 8'h00;
		flag0_view[TIMER_ZERO_BIT] = timer_zero_flag_reg;
		flag0_view[PIN_CHANGE_BIT] = pin_change_flag;
		flag0_view[EXT_PIN_BIT] = ext_pin_flag_reg;
	end

	// group0 needs only global enable, group1 also peripheral enable
	assign group0_hit = |(flag0_view & enable0_reg);
	assign group1_hit = control_reg[PERIPH_IRQ_ENABLE_BIT] & |(flag1_reg & enable1_reg);
	assign pending_any = group0_hit | group1_hit;
	assign request = control_reg[GIE_BIT] & pending_any;
	assign sample_q1 = (Q_PHASE == PHASE_Q1);
	// no entry while asleep or during the instruction after wake
	assign take_irq = sample_q1 & request & (state_reg == MIC_RUN) & ~IRQ_ENTRY;

	// ------------------------------------------------------------
	// instruction cycle phase counter
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			Q_PHASE <= PHASE_Q1;
		end else begin
			Q_PHASE <= Q_PHASE + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// external pin edge detector and flag
	// ------------------------------------------------------------
	// the set wins over a software clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ext_prev_reg <= 1'b0;
			ext_pin_flag_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_sync;
			if (bus_write && word_idx == IDX_FLAG_GROUP0) begin
				ext_pin_flag_reg <= PWDATA[EXT_PIN_BIT] | ext_edge;
			end else if (ext_edge) begin
				ext_pin_flag_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// timer zero and peripheral flags
	// ------------------------------------------------------------
	always_comb begin
		flag1_next = flag1_reg | PERIPH_EVENT;
		if (bus_write && word_idx == IDX_FLAG_GROUP1) begin
			flag1_next = PWDATA[7:0] | PERIPH_EVENT;
		end
		// receive/transmit bits follow their source, never written
		flag1_next = (flag1_next & ~GROUP1_LEVEL_MASK)
			| (PERIPH_EVENT & GROUP1_LEVEL_MASK);
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			timer_zero_flag_reg <= 1'b0;
			flag1_reg <= FLAG_RESET;
		end else begin
			flag1_reg <= flag1_next;
			if (bus_write && word_idx == IDX_FLAG_GROUP0) begin
				timer_zero_flag_reg <= PWDATA[TIMER_ZERO_BIT] | TIMER_ZERO_EVENT;
			end else if (TIMER_ZERO_EVENT) begin
				timer_zero_flag_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// control register: global enable, peripheral enable, edge
	// ------------------------------------------------------------
	// entry clear beats a software write landing in the same cycle,
	// so a handler can never be re-entered before it starts
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			control_reg <= INTERRUPT_CONTROL_RESET;
		end else begin
			if (bus_write && word_idx == IDX_INTERRUPT_CONTROL) begin
				control_reg <= PWDATA[7:0];
			end
			if (CORE_RETURN) begin
				control_reg[GIE_BIT] <= 1'b1;
			end
			if (take_irq) begin
				control_reg[GIE_BIT] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// enable registers and pin route
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			enable0_reg <= ENABLE_RESET;
			enable1_reg <= ENABLE_RESET;
			route_reg <= ROUTE_RESET;
		end else if (bus_write) begin
			if (word_idx == IDX_ENABLE_GROUP0) begin
				enable0_reg <= PWDATA[7:0] & 8'h31;
			end
			if (word_idx == IDX_ENABLE_GROUP1) begin
				enable1_reg <= PWDATA[7:0];
			end
			if (word_idx == IDX_EXT_PIN_ROUTE) begin
				route_reg <= PWDATA[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// shadow context
	// ------------------------------------------------------------
	// timeout and powerdown are not shadowed; entry loads them as zero
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < SHADOW_COUNT; i++) begin
				shadow_reg[i] <= SHADOW_RESET;
			end
		end else if (take_irq) begin
			for (int i = 0; i < SHADOW_COUNT; i++) begin
				shadow_reg[i] <= CORE_CONTEXT[i*8 +: 8];
			end
			shadow_reg[SHADOW_STATUS][TIMEOUT_BIT] <= 1'b0;
			shadow_reg[SHADOW_STATUS][POWERDOWN_BIT] <= 1'b0;
		end else if (bus_write && shadow_hit) begin
			shadow_reg[shadow_slot] <= PWDATA[7:0];
		end
	end

	// restore lines are the shadow flops themselves
	always_comb begin
		for (int i = 0; i < SHADOW_COUNT; i++) begin
			RESTORE_CONTEXT[i*8 +: 8] = shadow_reg[i];
		end
	end

	// ------------------------------------------------------------
	// core handshake: entry, return, vector
	// ------------------------------------------------------------
	// entry pulse appears in Q2 of the sampled instruction cycle; the
	// core flushes the prefetch, pushes its PC and loads VECTOR_PC
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			IRQ_ENTRY <= 1'b0;
			RESTORE_STROBE <= 1'b0;
			VECTOR_PC <= VECTOR_ADDR;
			IRQ_PENDING <= 1'b0;
		end else begin
			IRQ_ENTRY <= take_irq;
			RESTORE_STROBE <= CORE_RETURN;
			VECTOR_PC <= VECTOR_ADDR;
			IRQ_PENDING <= request;
		end
	end

	// ------------------------------------------------------------
	// sleep and wake sequencing
	// ------------------------------------------------------------
	// wake ignores global enable: any enabled pending source wakes
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_reg <= MIC_RUN;
			WAKE <= 1'b0;
		end else begin
			WAKE <= CORE_SLEEP & pending_any;
			unique case (state_reg)
				MIC_RUN: begin
					if (CORE_SLEEP && !take_irq) begin
						state_reg <= MIC_ASLEEP;
					end
				end
				MIC_ASLEEP: begin
					if (!CORE_SLEEP) begin
						state_reg <= MIC_WAKE_HOLD;
					end
				end
				MIC_WAKE_HOLD: begin
					// skip one Q1 sample so the next instruction runs
					if (sample_q1) begin
						state_reg <= MIC_RUN;
					end
				end
				default: state_reg <= MIC_RUN; // unused code falls back to run
			endcase
		end
	end

	// ------------------------------------------------------------
	// APB slave: no wait state, registered answer
	// ------------------------------------------------------------
	assign mapped = shadow_hit
		|| word_idx == IDX_INTERRUPT_CONTROL
		|| word_idx == IDX_FLAG_GROUP0
		|| word_idx == IDX_FLAG_GROUP1
		|| word_idx == IDX_ENABLE_GROUP0
		|| word_idx == IDX_ENABLE_GROUP1
		|| word_idx == IDX_CORE_STATUS
		|| word_idx == IDX_EXT_PIN_ROUTE;

	always_comb begin
		rd_next = 8'h00;
		if (shadow_hit) begin
			rd_next = shadow_reg[shadow_slot];
		end else begin
			unique case (word_idx)
				IDX_INTERRUPT_CONTROL: rd_next = control_reg;
				IDX_FLAG_GROUP0: rd_next = flag0_view;
				IDX_FLAG_GROUP1: rd_next = flag1_reg;
				IDX_ENABLE_GROUP0: rd_next = enable0_reg;
				IDX_ENABLE_GROUP1: rd_next = enable1_reg;
				IDX_EXT_PIN_ROUTE: rd_next = route_reg;
				IDX_CORE_STATUS: rd_next = {4'h0, state_reg, pending_any, request};
				default: rd_next = 8'h00;
			endcase
		end
	end

	// setup edge loads the answer; access edge completes
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pready_reg <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			pready_reg <= PSEL & ~PENABLE;
			if (PSEL && !PENABLE) begin
				PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_next};
				PSLVERR <= ~mapped;
			end else begin
				PSLVERR <= 1'b0;
			end
		end
	end

	assign PREADY = pready_reg;

endmodule

// File: verilog/mic_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser; first stage feeds only the second
module mic_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
